//--- rtl/php_dev_end.sv
// Reader side of the parallel host port: bus style detection and register access.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Separate strobes: read, write, select, address
// - Common strobe: direction, data strobe, select
// - Handshake style only multiplexed, four controls
// - High latch strobe latches address lines 0-5
// - Handshake: low address strobe latches address
// - Wait low starts access, high ends it
// - Dedicated address pins load address bits 0-2
// - Data lines form 8-bit two-way bus
// - Reset clears mode, detection runs again
// - Mode recognised from control pin levels
// - Board straps for separate strobe styles
// - Board straps for common and handshake styles
// - Reset/power-down high powers the port down
// - Falling reset/power-down starts reset phase
// - Serial mode reuses latch, address, data pins
// - Host asserts chip select for access
// - Host pulses separate write or read strobes
// - Host sets direction, then pulses data strobe
// - Wait pin floats until first address strobe
module php_dev_end
    import php_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins toward the host
    php_if.dev pins,
    // Register access toward the core
    output php_mode_e mode,
    output logic power_down,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] wr_data,
    output logic wr_stb,
    output logic rd_stb,
    input wire logic [DATA_W-1:0] rd_data,
    // Outcome of the initialization routine for dedicated address styles
    input wire logic init_common,
    // Serial pins handed to the core in serial mode
    output logic spi_nss,
    output logic spi_sck,
    output logic spi_mosi,
    input wire logic spi_miso
);
    typedef enum logic [3:0] {
        ST_OFF     = 4'h1,
        ST_PHASE   = 4'h2,
        ST_HS_PEND = 4'h4,
        ST_RUN     = 4'h8
    } php_dev_st_e;

    php_dev_st_e st_q, st_d;
    php_mode_e mode_q, mode_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic latch_q, latch_d;
    logic rd_act_q, rd_act_d;
    logic wr_act_q, wr_act_d;
    logic done_q, done_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic wr_stb_q, wr_stb_d;
    logic rd_stb_q, rd_stb_d;
    logic rd_act, wr_act, hs_busy, addr_open;
    logic is_mux, is_ded, is_hs;

    assign is_mux = (mode_q == PHP_MODE_SEP_MUX) || (mode_q == PHP_MODE_COM_MUX);
    assign is_ded = (mode_q == PHP_MODE_SEP_DED) || (mode_q == PHP_MODE_COM_DED);
    assign is_hs = (mode_q == PHP_MODE_HS_MUX);

    // Strobe decode per bus style.
    always_comb begin
        rd_act = 1'b0;
        wr_act = 1'b0;
        case (mode_q)
            PHP_MODE_SEP_DED, PHP_MODE_SEP_MUX: begin
                rd_act = !pins.chip_select_n && !pins.pin_rd;
                wr_act = !pins.chip_select_n && !pins.pin_wr;
            end
            PHP_MODE_COM_DED, PHP_MODE_COM_MUX: begin
                rd_act = !pins.chip_select_n && !pins.pin_rd && pins.pin_wr;
                wr_act = !pins.chip_select_n && !pins.pin_rd && !pins.pin_wr;
            end
            PHP_MODE_HS_MUX: begin
                // Chip select, when wired, inhibits the handshake data strobe.
                rd_act = !pins.chip_select_n && !pins.pin_rd && pins.pin_wr;
                wr_act = !pins.chip_select_n && !pins.pin_rd && !pins.pin_wr;
            end
            default: begin
                rd_act = 1'b0;
                wr_act = 1'b0;
            end
        endcase
    end

    assign addr_open = is_hs ? !pins.pin_latch : pins.pin_latch;
    assign hs_busy = rd_act || wr_act || !pins.pin_latch;

    always_comb begin
        st_d = st_q;
        mode_d = mode_q;
        cnt_d = cnt_q;
        latch_d = pins.pin_latch;
        rd_act_d = (st_q == ST_RUN) && rd_act;
        wr_act_d = (st_q == ST_RUN) && wr_act;
        done_d = 1'b0;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        wr_stb_d = 1'b0;
        rd_stb_d = 1'b0;
        case (st_q)
            ST_OFF: begin
                if (!pins.reset_powerdown) begin
                    st_d = ST_PHASE;
                    cnt_d = CNT_ZERO;
                end
            end
            ST_PHASE: begin
                if (cnt_q != RESET_PHASE_LAST) begin
                    cnt_d = cnt_q + CNT_ONE;
                end else if (!pins.addr_bit1 && pins.pin_rd && pins.pin_wr
                             && !pins.chip_select_n) begin
                    mode_d = PHP_MODE_SPI;
                    st_d = ST_RUN;
                end else if ({pins.addr_bit2, pins.addr_bit1} == STRAP_HS
                             && !pins.chip_select_n) begin
                    // The idle address strobe is high as well, so test before dedicated.
                    st_d = ST_HS_PEND;
                end else if (pins.pin_latch) begin
                    // Both dedicated styles strap the latch pin high.
                    mode_d = init_common ? PHP_MODE_COM_DED : PHP_MODE_SEP_DED;
                    st_d = ST_RUN;
                end else if ({pins.addr_bit2, pins.addr_bit1, pins.addr_bit0}
                             == STRAP_SEP_MUX) begin
                    mode_d = PHP_MODE_SEP_MUX;
                    st_d = ST_RUN;
                end else if ({pins.addr_bit2, pins.addr_bit1, pins.addr_bit0}
                             == STRAP_COM_MUX) begin
                    mode_d = PHP_MODE_COM_MUX;
                    st_d = ST_RUN;
                end
            end
            ST_HS_PEND: begin
                // The reset phase leaves its count behind; the wait timer starts clean.
                cnt_d = CNT_ZERO;
                // The first falling address strobe confirms the handshake style.
                if (latch_q && !pins.pin_latch) begin
                    mode_d = PHP_MODE_HS_MUX;
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                // Mode stays put; strap pins are now bus pins.
                mode_d = mode_q;
                if (is_ded && !rd_act && !wr_act) begin
                    addr_d = {DED_ADDR_PAD, pins.addr_bit2, pins.addr_bit1,
                              pins.addr_bit0};
                end else if ((is_mux || is_hs) && addr_open) begin
                    addr_d = pins.data_bus[ADDR_W-1:0];
                end
                if (wr_act) begin
                    wdata_d = pins.data_bus;
                end
                wr_stb_d = wr_act_q && !wr_act;
                rd_stb_d = rd_act && !rd_act_q;
                if (rd_act) begin
                    rdata_d = rd_data;
                end
                if (is_hs) begin
                    if (!hs_busy) begin
                        cnt_d = CNT_ZERO;
                    end else if (!done_q) begin
                        cnt_d = cnt_q + CNT_ONE;
                    end
                    done_d = hs_busy && (done_q || cnt_q == HS_ACCESS_LAST);
                end
            end
            default: begin
                st_d = ST_OFF;
            end
        endcase
        if (pins.reset_powerdown) begin
            st_d = ST_OFF;
            mode_d = PHP_MODE_NONE;
            cnt_d = CNT_ZERO;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= ST_OFF;
            mode_q <= PHP_MODE_NONE;
            cnt_q <= CNT_ZERO;
            latch_q <= 1'b0;
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            done_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= DATA_ZERO;
            rdata_q <= DATA_ZERO;
            wr_stb_q <= 1'b0;
            rd_stb_q <= 1'b0;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            latch_q <= latch_d;
            rd_act_q <= rd_act_d;
            wr_act_q <= wr_act_d;
            done_q <= done_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            wr_stb_q <= wr_stb_d;
            rd_stb_q <= rd_stb_d;
        end
    end

    // Wait pin: low while idle or working, high when the access is done.
    assign pins.addr_bit0_dev = done_q;
    assign pins.addr_bit0_dev_oe = is_hs;
    // The bus turns around one cycle into the read so stale data never drives.
    assign pins.data_bus_dev = (mode_q == PHP_MODE_SPI) ?
                               {DATA_ZERO[DATA_W-1:1], spi_miso} : rdata_q;
    assign pins.data_bus_dev_oe = (mode_q == PHP_MODE_SPI) ||
                                  (rd_act && rd_act_q);
    assign spi_nss = (mode_q == PHP_MODE_SPI) ? pins.pin_latch : 1'b1;
    assign spi_sck = (mode_q == PHP_MODE_SPI) && pins.addr_bit2;
    assign spi_mosi = (mode_q == PHP_MODE_SPI) && pins.addr_bit0;
    assign mode = mode_q;
    assign power_down = pins.reset_powerdown;
    assign reg_addr = addr_q;
    assign wr_data = wdata_q;
    assign wr_stb = wr_stb_q;
    assign rd_stb = rd_stb_q;
endmodule : php_dev_end
`default_nettype wire

//--- rtl/php_host_end.sv
// Host side of the parallel port: drives straps and runs one access per command.
`timescale 1ns/1ps
`default_nettype none
module php_host_end
    import php_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins toward the reader
    php_if.host pins,
    // Bus style and hard reset requested by the user
    input wire php_mode_e bus_mode,
    input wire logic hard_reset,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_wdata,
    output logic cmd_ready,
    // Read answer
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data
);
    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_ADDR = 5'h02,
        H_GAP  = 5'h04,
        H_DATA = 5'h08,
        H_DONE = 5'h10
    } php_host_st_e;

    php_host_st_e st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic write_q, write_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic rsp_q, rsp_d;
    logic is_mux, is_hs, is_par, phase_end, step;

    assign is_hs = (bus_mode == PHP_MODE_HS_MUX);
    assign is_mux = (bus_mode == PHP_MODE_SEP_MUX) || (bus_mode == PHP_MODE_COM_MUX) || is_hs;
    assign is_par = is_mux || (bus_mode == PHP_MODE_SEP_DED) || (bus_mode == PHP_MODE_COM_DED);
    assign phase_end = (cnt_q == HOST_PHASE_LAST);

    // In handshake style each phase also waits for the wait pin.
    always_comb begin
        step = phase_end;
        if (is_hs) begin
            case (st_q)
                H_ADDR, H_DATA: step = phase_end && pins.addr_bit0;
                H_GAP, H_DONE: step = phase_end && !pins.addr_bit0;
                default: step = phase_end;
            endcase
        end
    end

    always_comb begin
        st_d = st_q;
        cnt_d = (st_q == H_IDLE || step) ? CNT_ZERO : cnt_q + CNT_ONE;
        write_d = write_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        rsp_d = 1'b0;
        case (st_q)
            H_IDLE: begin
                if (cmd_valid && cmd_ready) begin
                    write_d = cmd_write;
                    addr_d = cmd_addr;
                    wdata_d = cmd_wdata;
                    st_d = is_mux ? H_ADDR : H_GAP;
                end
            end
            H_ADDR: if (step) st_d = H_GAP;
            H_GAP: if (step) st_d = H_DATA;
            H_DATA: begin
                if (step) begin
                    st_d = H_DONE;
                    rsp_d = !write_q;
                    rdata_d = pins.data_bus;
                end
            end
            H_DONE: if (step) st_d = H_IDLE;
            default: st_d = H_IDLE;
        endcase
        if (hard_reset) begin
            st_d = H_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= H_IDLE;
            cnt_q <= CNT_ZERO;
            write_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= DATA_ZERO;
            rdata_q <= DATA_ZERO;
            rsp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            write_q <= write_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            rsp_q <= rsp_d;
        end
    end

    // Pin drive per style; straps stand whenever the host is out of reset.
    always_comb begin
        pins.pin_latch = 1'b1;
        {pins.addr_bit2, pins.addr_bit1, pins.addr_bit0_host} = addr_q[DED_ADDR_W-1:0];
        pins.addr_bit0_host_oe = !is_hs;
        pins.pin_rd = 1'b1;
        pins.pin_wr = 1'b1;
        pins.chip_select_n = !(st_q == H_GAP || st_q == H_DATA);
        case (bus_mode)
            PHP_MODE_SEP_MUX: begin
                pins.pin_latch = (st_q == H_ADDR);
                {pins.addr_bit2, pins.addr_bit1, pins.addr_bit0_host} = STRAP_SEP_MUX;
            end
            PHP_MODE_COM_MUX: begin
                pins.pin_latch = (st_q == H_ADDR);
                {pins.addr_bit2, pins.addr_bit1, pins.addr_bit0_host} = STRAP_COM_MUX;
            end
            PHP_MODE_HS_MUX: begin
                pins.pin_latch = !(st_q == H_ADDR);
                {pins.addr_bit2, pins.addr_bit1} = STRAP_HS;
                pins.chip_select_n = 1'b0;
            end
            PHP_MODE_SPI: begin
                pins.addr_bit1 = 1'b0;
                pins.chip_select_n = 1'b0;
            end
            default: pins.pin_latch = 1'b1;
        endcase
        case (bus_mode)
            PHP_MODE_SEP_DED, PHP_MODE_SEP_MUX: begin
                pins.pin_rd = !(st_q == H_DATA && !write_q);
                pins.pin_wr = !(st_q == H_DATA && write_q);
            end
            PHP_MODE_COM_DED, PHP_MODE_COM_MUX: begin
                pins.pin_wr = !(write_q && (st_q == H_GAP || st_q == H_DATA));
                pins.pin_rd = !(st_q == H_DATA);
            end
            PHP_MODE_HS_MUX: begin
                pins.pin_wr = !(st_q == H_ADDR || (write_q && st_q != H_IDLE));
                pins.pin_rd = !(st_q == H_DATA);
            end
            default: pins.pin_rd = 1'b1;
        endcase
        if (!rst_n) begin
            pins.chip_select_n = 1'b1;
        end
    end

    assign pins.data_bus_host = (st_q == H_ADDR) ? {MUX_ADDR_PAD, addr_q} : wdata_q;
    assign pins.data_bus_host_oe = (st_q == H_ADDR) ||
                                   (write_q && (st_q == H_GAP || st_q == H_DATA));
    assign pins.reset_powerdown = hard_reset;
    assign cmd_ready = (st_q == H_IDLE) && is_par && !hard_reset;
    assign rsp_valid = rsp_q;
    assign rsp_data = rdata_q;
endmodule : php_host_end
`default_nettype wire

//--- rtl/php_if.sv
// Pin bundle between the reader port and the host, with two-way pin resolution.
`timescale 1ns/1ps
`default_nettype none
interface php_if;
    import php_pkg::*;
    logic pin_latch;
    logic addr_bit2;
    logic addr_bit1;
    logic addr_bit0_host;
    logic addr_bit0_host_oe;
    logic addr_bit0_dev;
    logic addr_bit0_dev_oe;
    logic addr_bit0;
    logic pin_rd;
    logic pin_wr;
    logic chip_select_n;
    logic reset_powerdown;
    logic [DATA_W-1:0] data_bus_host;
    logic data_bus_host_oe;
    logic [DATA_W-1:0] data_bus_dev;
    logic data_bus_dev_oe;
    logic [DATA_W-1:0] data_bus;
    // An undriven address pin 0 floats high through a board pull-up.
    assign addr_bit0 = addr_bit0_dev_oe ? addr_bit0_dev :
                       (addr_bit0_host_oe ? addr_bit0_host : 1'b1);
    assign data_bus = data_bus_dev_oe ? data_bus_dev :
                      (data_bus_host_oe ? data_bus_host : DATA_ZERO);
    modport dev (
        input pin_latch, addr_bit2, addr_bit1, addr_bit0, pin_rd, pin_wr,
        input chip_select_n, reset_powerdown, data_bus,
        output addr_bit0_dev, addr_bit0_dev_oe, data_bus_dev, data_bus_dev_oe
    );
    modport host (
        output pin_latch, addr_bit2, addr_bit1, addr_bit0_host, addr_bit0_host_oe,
        output pin_rd, pin_wr, chip_select_n, reset_powerdown,
        output data_bus_host, data_bus_host_oe,
        input addr_bit0, data_bus
    );
endinterface : php_if
`default_nettype wire

//--- rtl/php_pkg.sv
// Shared constants and types of the parallel host port with bus style detection.
package php_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int RESET_PHASE_NS = 1000;
    localparam int RESET_PHASE_CYC = (RESET_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HS_ACCESS_NS = 16;
    localparam int HS_ACCESS_CYC = (HS_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOST_PHASE_NS = 40;
    localparam int HOST_PHASE_CYC = (HOST_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] RESET_PHASE_LAST = CNT_W'(RESET_PHASE_CYC - 1);
    localparam logic [CNT_W-1:0] HS_ACCESS_LAST = CNT_W'(HS_ACCESS_CYC - 1);
    localparam logic [CNT_W-1:0] HOST_PHASE_LAST = CNT_W'(HOST_PHASE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int DED_ADDR_W = 3;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [ADDR_W-DED_ADDR_W-1:0] DED_ADDR_PAD = 3'h0;
    localparam logic [DATA_W-ADDR_W-1:0] MUX_ADDR_PAD = 2'h0;
    // Strap levels on address pins 2..0 (2..1 for handshake) that name the multiplexed styles.
    localparam logic [2:0] STRAP_SEP_MUX = 3'h3;
    localparam logic [2:0] STRAP_COM_MUX = 3'h2;
    localparam logic [1:0] STRAP_HS = 2'h3;
    typedef enum logic [6:0] {
        PHP_MODE_NONE    = 7'h01,
        PHP_MODE_SEP_DED = 7'h02,
        PHP_MODE_SEP_MUX = 7'h04,
        PHP_MODE_COM_DED = 7'h08,
        PHP_MODE_COM_MUX = 7'h10,
        PHP_MODE_HS_MUX  = 7'h20,
        PHP_MODE_SPI     = 7'h40
    } php_mode_e;
endpackage : php_pkg

//--- test/php_bench.sv
// Bench running every parallel bus style through detection, writes and reads, then serial detection.
`timescale 1ns/1ps
`default_nettype none
module php_bench
    import php_pkg::*;
;
    localparam php_mode_e STYLES [5] = '{PHP_MODE_SEP_DED, PHP_MODE_SEP_MUX,
        PHP_MODE_COM_DED, PHP_MODE_COM_MUX, PHP_MODE_HS_MUX};
    localparam logic [ADDR_W-1:0] ADR [2] = '{6'h2d, 6'h12};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    php_mode_e bus_mode = PHP_MODE_SEP_DED;
    logic hard_reset = 1'b0;
    logic init_common = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [ADDR_W-1:0] cmd_addr = 6'h00;
    logic [DATA_W-1:0] cmd_wdata = 8'h00;
    php_mode_e mode;
    logic power_down;
    logic wr_stb;
    logic rd_stb;
    logic cmd_ready;
    logic rsp_valid;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] rsp_data;
    logic [DATA_W-1:0] rd_data;
    logic spi_nss;
    logic spi_miso = 1'b0;
    logic [DATA_W-1:0] mem [64];
    int n_rd = 0;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    always #4 clock = ~clock;

    php_if link();
    php_dev_end u_php_dev_end (.clock(clock), .rst_n(rst_n), .pins(link.dev), .mode(mode),
        .power_down(power_down), .reg_addr(reg_addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .init_common(init_common), .spi_nss(spi_nss),
        .spi_sck(), .spi_mosi(), .spi_miso(spi_miso));
    php_host_end u_php_host_end (.clock(clock), .rst_n(rst_n), .pins(link.host),
        .bus_mode(bus_mode), .hard_reset(hard_reset), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    php_link_assertions u_php_link_assertions (.clock(clock), .rst_n(rst_n),
        .pin_latch(link.pin_latch), .addr_bit0(link.addr_bit0),
        .addr_bit0_dev_oe(link.addr_bit0_dev_oe), .pin_rd(link.pin_rd), .pin_wr(link.pin_wr),
        .chip_select_n(link.chip_select_n), .reset_powerdown(link.reset_powerdown),
        .data_bus_dev_oe(link.data_bus_dev_oe), .spi_mode(mode == PHP_MODE_SPI));

    // A small register file stands in for the reader core.
    assign rd_data = mem[reg_addr];
    always @(posedge clock) begin
        if (wr_stb === 1'b1) mem[reg_addr] <= wr_data;
        if (rd_stb === 1'b1) n_rd++;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // The whole run needs under two thousand cycles; a hung handshake ends here.
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    // One host command, held until taken; returns at the write strobe or read answer.
    task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic [5:0] ra);
        int n;
        n = 0;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_valid <= 1'b1;
        @(posedge clock);
        while (cmd_ready !== 1'b1) @(posedge clock);
        cmd_valid <= 1'b0;
        @(posedge clock);
        while ((w ? wr_stb : rsp_valid) !== 1'b1 && n < 300) begin
            @(posedge clock);
            n++;
        end
        if (n == 300) chk("access completion", 8'h01, 8'h00);
        q = w ? wr_data : rsp_data;
        ra = reg_addr;
    endtask : access

    initial begin
        logic [7:0] q;
        logic [5:0] ra;
        logic [7:0] dv [2];
        logic ded;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            ded = (STYLES[i] == PHP_MODE_SEP_DED) || (STYLES[i] == PHP_MODE_COM_DED);
            bus_mode <= STYLES[i];
            init_common <= (STYLES[i] == PHP_MODE_COM_DED);
            hard_reset <= 1'b1;
            repeat (4) @(posedge clock);
            chk("power_down", 8'h01, 8'(power_down));
            chk("mode in reset", 8'(PHP_MODE_NONE), 8'(mode));
            hard_reset <= 1'b0;
            repeat (140) @(posedge clock);
            access(1'b1, 6'h00, 8'h00, q, ra);
            chk("mode", 8'(STYLES[i]), 8'(mode));
            init_common <= ~init_common;
            repeat (4) @(posedge clock);
            chk("mode held", 8'(STYLES[i]), 8'(mode));
            init_common <= ~init_common;
            for (int j = 0; j < 2; j++) begin
                dv[j] = 8'(8'h31 + i * 16 + j);
                access(1'b1, ADR[j], dv[j], q, ra);
                chk("write addr", 8'(ded ? (ADR[j] & 6'h07) : ADR[j]), 8'(ra));
                chk("write data", dv[j], q);
            end
            for (int j = 0; j < 2; j++) begin
                access(1'b0, ADR[j], 8'h00, q, ra);
                chk("read data", dv[j], q);
            end
            chk("read strobes", 8'(2 * i + 2), 8'(n_rd));
            $display("style %0d done", i);
        end
        bus_mode <= PHP_MODE_SPI;
        hard_reset <= 1'b1;
        repeat (4) @(posedge clock);
        hard_reset <= 1'b0;
        repeat (140) @(posedge clock);
        chk("spi mode", 8'(PHP_MODE_SPI), 8'(mode));
        chk("spi select", 8'h01, 8'(spi_nss));
        for (int k = 0; k < 2; k++) begin
            spi_miso <= k[0];
            repeat (2) @(posedge clock);
            chk("miso on data 0", 8'(k), 8'(link.data_bus));
        end
        $display("style spi done");
        close_out();
    end
endmodule : php_bench
`default_nettype wire

//--- test/php_link_assertions.sv
// Checks on the pins between the reader port and its host.
`timescale 1ns/1ps
`default_nettype none
module php_link_assertions
    import php_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link pins
    input wire logic pin_latch,
    input wire logic addr_bit0,
    input wire logic addr_bit0_dev_oe,
    input wire logic pin_rd,
    input wire logic pin_wr,
    input wire logic chip_select_n,
    input wire logic reset_powerdown,
    input wire logic data_bus_dev_oe,
    // Decoded style of the reader end
    input wire logic spi_mode
);
    logic [CNT_W-1:0] phase_q;
    logic [CNT_W-1:0] phase_d;
    logic seen_q;
    logic seen_d;
    logic latch_q;

    // The count saturates so a long run never wraps back into the reset phase.
    always_comb begin
        phase_d = (phase_q == 8'hff) ? phase_q : phase_q + CNT_ONE;
        seen_d = seen_q || (latch_q && !pin_latch);
        if (!rst_n || reset_powerdown) begin
            phase_d = CNT_ZERO;
            seen_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        phase_q <= phase_d;
        seen_q <= seen_d;
        latch_q <= pin_latch;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    bus_drive_read_a: assert property (data_bus_dev_oe && !spi_mode |->
        !chip_select_n && pin_wr && !$past(pin_rd)) else $error("data bus driven outside a read");
    bus_release_a: assert property ($rose(pin_rd) |=> !data_bus_dev_oe)
        else $error("data bus still driven after read strobe");
    powerdown_quiet_a: assert property (reset_powerdown |=>
        !data_bus_dev_oe && !addr_bit0_dev_oe) else $error("pins driven in power-down");
    phase_quiet_a: assert property ((data_bus_dev_oe || addr_bit0_dev_oe) |->
        phase_q > RESET_PHASE_LAST) else $error("pins driven during reset phase");
    reset_clear_a: assert property ($rose(rst_n) |->
        !data_bus_dev_oe && !addr_bit0_dev_oe) else $error("pins driven after reset");
    wait_float_a: assert property (addr_bit0_dev_oe |->
        seen_q || (latch_q && !pin_latch)) else $error("wait driven before address strobe");
    wait_rise_a: assert property ($past(addr_bit0_dev_oe) && $rose(addr_bit0) |->
        !pin_rd || !pin_latch) else $error("wait rose with no strobe active");
    wait_done_a: assert property (addr_bit0_dev_oe && addr_bit0 &&
        ($rose(pin_rd) || $rose(pin_latch)) |-> ##[0:2] !addr_bit0)
        else $error("wait not lowered after strobe release");
    wait_answer_a: assert property (addr_bit0_dev_oe && !addr_bit0 && $fell(pin_rd)
        |-> ##[1:8] addr_bit0) else $error("wait never raised during access");

    cover property (data_bus_dev_oe && !pin_rd);
    cover property (addr_bit0_dev_oe && $rose(addr_bit0));
    cover property ($fell(reset_powerdown));
    cover property (spi_mode && data_bus_dev_oe);
endmodule : php_link_assertions
`default_nettype wire
